// file: logic/mci_consts.svh
/*
 Constants of the monitor control and interrupt status block: register indices, bit positions,
 reset values and the reset pulse time. Assumes inclusion by logic/mci_top.sv only.
*/
`ifndef MCI_CONSTS_SVH
`define MCI_CONSTS_SVH

// Register indices; the byte address is four times the index
`define MCI_IDX_CFG      8'h40
`define MCI_IDX_ST1      8'h41
`define MCI_IDX_ST2      8'h42
`define MCI_IDX_MSK1     8'h43
`define MCI_IDX_MSK2     8'h44

// Main control bit positions
`define MCI_B_START      0
`define MCI_B_ALERT_EN   1
`define MCI_B_OT_EN      2
`define MCI_B_ALERT_CLR  3
`define MCI_B_RST        4
`define MCI_B_OT_REL     6
`define MCI_B_INIT       7

// Error flags two bit positions
`define MCI_B_INTRUSION  4
`define MCI_B_OT_PIN     5

// Bits of main control kept as written, and reset values
`define MCI_CFG_KEEP     8'h2F
`define MCI_RST_CFG      8'h00
`define MCI_RST_ST       8'h00
`define MCI_RST_MSK      8'h00

// Reset pulse time and clock rate
`define MCI_RST_PULSE_MS 45
`define MCI_CLK_KHZ      125000

`endif

// file: logic/mci_pkg.sv
/*
 Types of the monitor control and interrupt status block.
 Assumes logic/mci_consts.svh for all numeric constants but the mci_rst_e encodings.
*/
package mci_pkg;

	typedef enum logic [1:0] {
		MCI_IDLE  = 2'b01,
		MCI_PULSE = 2'b10
	} mci_rst_e;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [9:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} mci_wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} mci_wb_rsp_s;

	typedef struct packed {
		logic [7:0] limit_one;
		logic [1:0] limit_two;
		logic [1:0] temp_irq;
		logic [1:0] diode_fault;
	} mci_evt_s;

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] st1;
		logic [7:0] st2;
		logic [7:0] msk1;
		logic [7:0] msk2;
		logic       ack;
		logic [7:0] dat;
		logic       alert;
		logic       ot_hold;
		logic       ot_drive;
		logic [2:0] ot_hist;
		logic       intr_s1;
		logic       intr_s2;
		logic       intr_prev;
		logic       ot_s1;
		logic       ot_s2;
		logic       ot_prev;
		mci_rst_e   rst_st;
		logic [22:0] rst_cnt;
	} mci_state_s;

endpackage

// file: logic/mci_top.sv
/*
 Monitor control and interrupt status: main control register, two clear-on-read error flag
 registers with masks, active-low alert, open-drain over-temperature pin and reset pulse.
 Assumes a classic Wishbone master on the same clock and limit, temperature and diode events
 from the conversion datapath, synchronous to clock, one bit per channel, high while true.
*/
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`include "mci_consts.svh"

module mci_top #(
	parameter int unsigned RST_PULSE_CYC = `MCI_RST_PULSE_MS * `MCI_CLK_KHZ
) (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_b,
	// Register bus
	input  wire mci_pkg::mci_wb_req_s wb_req,
	output      mci_pkg::mci_wb_rsp_s wb_rsp,
	// Datapath events and controls
	input  wire mci_pkg::mci_evt_s    evt,
	output      logic                 scan_enable,
	output      logic                 soft_init,
	// Pins
	input  wire logic                 intrusion_pin,
	input  wire logic                 overtemp_in,
	output      logic                 overtemp_out,
	output      logic                 overtemp_oe,
	output      logic                 alert_b,
	output      logic                 reset_out_b
);
	import mci_pkg::*;

	mci_state_s s;
	mci_state_s n;

	logic       hit;
	logic       wr;
	logic       rd;
	logic       mon;
	logic [7:0] wdat;
	logic [7:0] rval;
	logic [7:0] set1;
	logic [7:0] set2;
	logic [7:0] clr1;
	logic [7:0] clr2;
	logic       intr_rise;
	logic       ot_fall;
	logic       pulse_go;

	// Request is acted on at the edge where ack is seen high
	assign hit  = wb_req.cyc & wb_req.stb & s.ack;
	assign wr   = hit & wb_req.we & wb_req.sel[0];
	assign rd   = hit & ~wb_req.we;
	assign wdat = wb_req.dat[7:0];

	// Alert clear also suspends monitoring
	assign mon = s.cfg[`MCI_B_START] & ~s.cfg[`MCI_B_ALERT_CLR];

	// Only synchronised pin levels are looked at
	assign intr_rise = s.intr_s2 & ~s.intr_prev;
	// Our own drive also pulls the pin low; ignore it until its echo has passed the synchroniser
	assign ot_fall   = ~s.ot_s2 & s.ot_prev & ~(|s.ot_hist) & ~s.ot_drive;

	assign set1 = (evt.limit_one | {2'b00, evt.temp_irq, 4'b0000}) & {8{mon}};
	assign set2 = {evt.diode_fault & {2{mon}}, ot_fall, intr_rise, 2'b00,
		evt.limit_two & {2{mon}}};

	assign pulse_go = wr && (wb_req.adr[9:2] == `MCI_IDX_CFG) && wdat[`MCI_B_RST];

	// Read value decode
	always_comb begin
		rval = 8'h00;
		if (wb_req.adr[9:2] == `MCI_IDX_CFG) begin
			rval = s.cfg;
			rval[`MCI_B_RST] = (s.rst_st == MCI_PULSE);
		end else if (wb_req.adr[9:2] == `MCI_IDX_ST1) begin
			rval = s.st1;
		end else if (wb_req.adr[9:2] == `MCI_IDX_ST2) begin
			rval = s.st2;
		end else if (wb_req.adr[9:2] == `MCI_IDX_MSK1) begin
			rval = s.msk1;
		end else if (wb_req.adr[9:2] == `MCI_IDX_MSK2) begin
			rval = s.msk2;
		end
	end

	// Clears: the value that went out on the bus, or a write of ones
	always_comb begin
		clr1 = 8'h00;
		clr2 = 8'h00;
		if (wb_req.adr[9:2] == `MCI_IDX_ST1) begin
			if (rd) begin
				clr1 = s.dat;
			end else if (wr) begin
				clr1 = wdat;
			end
		end else if (wb_req.adr[9:2] == `MCI_IDX_ST2) begin
			if (rd) begin
				clr2 = s.dat;
			end else if (wr) begin
				clr2 = wdat;
			end
		end
	end

	always_comb begin
		n = s;

		// Bus slave: one wait state, ack for one cycle
		n.ack = wb_req.cyc & wb_req.stb & ~s.ack;
		if (~s.ack) begin
			n.dat = rval;
		end

		// Pin synchronisers
		n.intr_s1   = intrusion_pin;
		n.intr_s2   = s.intr_s1;
		n.intr_prev = s.intr_s2;
		n.ot_s1     = overtemp_in;
		n.ot_s2     = s.ot_s1;
		n.ot_prev   = s.ot_s2;
		n.ot_hist   = {s.ot_hist[1:0], s.ot_drive};

		// Sticky flags; a new event wins over a clear in the same cycle
		n.st1 = (s.st1 & ~clr1) | set1;
		n.st2 = (s.st2 & ~clr2) | set2;

		if (wr) begin
			if (wb_req.adr[9:2] == `MCI_IDX_CFG) begin
				n.cfg = wdat & `MCI_CFG_KEEP;
				if (wdat[`MCI_B_OT_REL]) begin
					n.ot_hold = 1'b0;
				end
			end else if (wb_req.adr[9:2] == `MCI_IDX_MSK1) begin
				n.msk1 = wdat;
			end else if (wb_req.adr[9:2] == `MCI_IDX_MSK2) begin
				n.msk2 = wdat;
			end
		end

		// Soft init wipes control, flags and masks; a same-cycle event still lands
		if (soft_init) begin
			n.cfg  = `MCI_RST_CFG;
			n.st1  = `MCI_RST_ST | set1;
			n.st2  = `MCI_RST_ST | set2;
			n.msk1 = `MCI_RST_MSK;
			n.msk2 = `MCI_RST_MSK;
		end

		// Over-temperature hold; a new event beats the release
		if (|evt.temp_irq) begin
			n.ot_hold = 1'b1;
		end
		n.ot_drive = s.cfg[`MCI_B_OT_EN] & s.ot_hold;

		// Alert does not look at start, so standby keeps it asserted
		n.alert = s.cfg[`MCI_B_ALERT_EN] & ~s.cfg[`MCI_B_ALERT_CLR]
			& (|((s.st1 & ~s.msk1) | (s.st2 & ~s.msk2)));

		// Reset pulse; a second request during the pulse is ignored
		case (s.rst_st)
			MCI_IDLE: begin
				n.rst_cnt = 23'd0;
				if (pulse_go) begin
					n.rst_st = MCI_PULSE;
				end
			end
			MCI_PULSE: begin
				n.rst_cnt = s.rst_cnt + 23'd1;
				if (s.rst_cnt == 23'(RST_PULSE_CYC - 1)) begin
					n.rst_st  = MCI_IDLE;
					n.rst_cnt = 23'd0;
				end
			end
			default: begin
				n.rst_st  = MCI_IDLE;
				n.rst_cnt = 23'd0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s.cfg       <= `MCI_RST_CFG;
			s.st1       <= `MCI_RST_ST;
			s.st2       <= `MCI_RST_ST;
			s.msk1      <= `MCI_RST_MSK;
			s.msk2      <= `MCI_RST_MSK;
			s.ack       <= 1'b0;
			s.dat       <= 8'h00;
			s.alert     <= 1'b0;
			s.ot_hold   <= 1'b0;
			s.ot_drive  <= 1'b0;
			s.ot_hist   <= 3'b000;
			s.intr_s1   <= 1'b0;
			s.intr_s2   <= 1'b0;
			s.intr_prev <= 1'b0;
			s.ot_s1     <= 1'b1;
			s.ot_s2     <= 1'b1;
			s.ot_prev   <= 1'b1;
			s.rst_st    <= MCI_IDLE;
			s.rst_cnt   <= 23'd0;
		end else begin
			s <= n;
		end
	end

	// Outputs
	assign soft_init    = wr && (wb_req.adr[9:2] == `MCI_IDX_CFG) && wdat[`MCI_B_INIT];
	assign wb_rsp.ack   = s.ack;
	assign wb_rsp.dat   = {24'h0000_00, s.dat};
	assign scan_enable  = mon;
	assign alert_b      = ~s.alert;
	assign overtemp_out = 1'b0;
	assign overtemp_oe  = s.ot_drive;
	assign reset_out_b  = (s.rst_st != MCI_PULSE);

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	a_ack_one_cycle: assert property (s.ack |=> !s.ack)
		else $error("ack held longer than one cycle");

	a_start_scan: assert property (s.cfg[`MCI_B_START] && !s.cfg[`MCI_B_ALERT_CLR] |-> scan_enable)
		else $error("start set but scanning off");

	a_start_written: assert property (wr && wb_req.adr[9:2] == `MCI_IDX_CFG && !wdat[`MCI_B_INIT]
		|=> s.cfg[`MCI_B_START] == $past(wdat[`MCI_B_START]))
		else $error("start bit did not follow write");

	a_alert_hold: assert property (!alert_b && !hit && !$past(hit) |=> !alert_b)
		else $error("alert released without a clear");

	a_alert_gate: assert property (!s.cfg[`MCI_B_ALERT_EN] |=> alert_b)
		else $error("alert asserted while disabled");

	a_ot_gate: assert property (!s.cfg[`MCI_B_OT_EN] |=> !overtemp_oe)
		else $error("overtemp driven while disabled");

	a_clr_suspend: assert property (s.cfg[`MCI_B_ALERT_CLR] |-> !scan_enable ##1 alert_b)
		else $error("alert clear did not release or suspend");

	a_clr_keeps: assert property (s.cfg[`MCI_B_ALERT_CLR] && !hit
		|=> ((s.st1 & $past(s.st1)) == $past(s.st1)) && ((s.st2 & $past(s.st2)) == $past(s.st2)))
		else $error("flags changed under alert clear");

	a_pulse_start: assert property (pulse_go && s.rst_st == MCI_IDLE |=> !reset_out_b)
		else $error("reset pulse did not start");

	a_pulse_bound: assert property (!reset_out_b |-> s.rst_cnt < 23'(RST_PULSE_CYC))
		else $error("reset pulse overran");

	a_pulse_end: assert property (!reset_out_b && s.rst_cnt == 23'(RST_PULSE_CYC - 1) |=> reset_out_b)
		else $error("reset pulse did not end");

	a_ot_release: assert property (wr && wb_req.adr[9:2] == `MCI_IDX_CFG && wdat[`MCI_B_OT_REL]
		&& evt.temp_irq == 2'b00 |-> ##2 !overtemp_oe)
		else $error("overtemp not released");

	a_init_restore: assert property (soft_init |=> s.cfg == `MCI_RST_CFG && s.msk1 == `MCI_RST_MSK
		&& s.msk2 == `MCI_RST_MSK && s.st1 == $past(set1) && s.st2 == $past(set2))
		else $error("init did not restore defaults");

	a_limit_latch: assert property (mon && evt.limit_one != 8'h00 |=> (s.st1 & $past(evt.limit_one))
		== $past(evt.limit_one))
		else $error("limit violation not latched");

	a_temp_latch: assert property (mon && evt.temp_irq[1] |=> s.st1[5])
		else $error("temperature event not latched");

	a_two_latch: assert property (mon && evt.limit_two[0] |=> s.st2[0] && s.st2[3:2] == 2'b00)
		else $error("flags two latch wrong");

	a_intr_latch: assert property (intr_rise |=> s.st2[`MCI_B_INTRUSION])
		else $error("intrusion not latched");

	a_otpin_latch: assert property (ot_fall |=> s.st2[`MCI_B_OT_PIN])
		else $error("external overtemp not latched");

	a_diode_latch: assert property (mon && evt.diode_fault[1] |=> s.st2[7])
		else $error("diode fault not latched");

	a_read_clear: assert property (rd && wb_req.adr[9:2] == `MCI_IDX_ST1 && set1 == 8'h00
		|=> (s.st1 & $past(s.dat)) == 8'h00)
		else $error("read did not clear flags");

	a_pending_rearm: assert property (rd && wb_req.adr[9:2] == `MCI_IDX_ST1 && set1 != 8'h00
		|=> (s.st1 & $past(set1)) == $past(set1))
		else $error("pending condition lost on read");

	a_alert_on: assert property (s.cfg[`MCI_B_ALERT_EN] && !s.cfg[`MCI_B_ALERT_CLR]
		&& ((s.st1 & ~s.msk1) != 8'h00) |=> !alert_b)
		else $error("alert missing");

	// Flags two bits 3:2 have no source and must read zero
	a_reserved_zero: assert property (s.st2[3:2] == 2'b00)
		else $error("reserved flags bits set");

	a_scan_off: assert property (!s.cfg[`MCI_B_START] |-> !scan_enable)
		else $error("scanning while stopped");

	a_standby_hold: assert property (!mon && !hit |=> (s.st1 & ~$past(s.st1)) == 8'h00)
		else $error("flags one set while not monitoring");

	a_status_read: assert property (wb_rsp.ack && !wb_req.we && wb_req.adr[9:2] == `MCI_IDX_ST1
		|-> wb_rsp.dat[7:0] == $past(s.st1))
		else $error("flags one read value wrong");

	// Write-one clear is an extra path beside read-clear; a same-cycle event still wins
	a_write_one_clear: assert property (wr && wb_req.adr[9:2] == `MCI_IDX_ST2
		|=> (s.st2 & $past(wdat) & ~$past(set2)) == 8'h00)
		else $error("write of ones did not clear flags two");

	a_release_keeps: assert property (wr && wb_req.adr[9:2] == `MCI_IDX_CFG && wdat[`MCI_B_OT_REL]
		&& !wdat[`MCI_B_INIT] |=> ((s.st1 & $past(s.st1)) == $past(s.st1))
		&& ((s.st2 & $past(s.st2)) == $past(s.st2)))
		else $error("overtemp release changed flags");

	a_ot_set: assert property (|evt.temp_irq && s.cfg[`MCI_B_OT_EN] && !hit |-> ##2 overtemp_oe)
		else $error("overtemp not driven after event");

	a_pulse_count: assert property (s.rst_st == MCI_PULSE && s.rst_cnt != 23'(RST_PULSE_CYC - 1)
		|=> s.rst_cnt == $past(s.rst_cnt) + 23'd1)
		else $error("reset pulse counter skipped");

	a_init_strobe: assert property (soft_init |=> !soft_init)
		else $error("init strobe longer than one cycle");

	a_mask_quiet: assert property (((s.st1 & ~s.msk1) | (s.st2 & ~s.msk2)) == 8'h00 |=> alert_b)
		else $error("alert without an unmasked flag");

	a_ack_request: assert property (wb_rsp.ack |-> $past(wb_req.cyc && wb_req.stb))
		else $error("ack without a request");

	c_read_clear: cover property (rd && wb_req.adr[9:2] == `MCI_IDX_ST1 && s.dat != 8'h00);

	c_alert: cover property (alert_b ##1 !alert_b);

	c_pulse: cover property (reset_out_b ##1 !reset_out_b);

	c_init: cover property (soft_init);

	c_ot_drive: cover property (!overtemp_oe ##1 overtemp_oe);

endmodule

// file: tb/testbench.sv
/*
 Self-checking testbench of mci_top: control register, flags, masks, alert, over-temp, reset pulse.
 Assumes mci_pkg compiled first and the design's constants header on the include path.
*/
`timescale 1ns/1ps
module testbench;
	import mci_pkg::*;
	typedef struct packed {
		logic       rd;
		logic [9:0] adr;
		logic [7:0] exp;
	} mci_note_s;
	// Short pulse keeps the run brief
	localparam int unsigned PULSE = 20;
	localparam int unsigned LIMIT = 20000;
	localparam logic [9:0] A_CFG = 10'h100, A_ST1 = 10'h104, A_ST2 = 10'h108;
	localparam logic [9:0] A_MK1 = 10'h10C, A_MK2 = 10'h110, A_BAD = 10'h3FC;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	mci_wb_req_s wb_req = '0;
	mci_wb_rsp_s wb_rsp;
	mci_evt_s    evt = '0;
	logic        intrusion_pin = 1'b0;
	logic        ext_low = 1'b0;
	logic        scan_enable, soft_init, overtemp_out, overtemp_oe, alert_b, reset_out_b;
	// Open-drain pin with pull-up
	wire logic   overtemp_in = ~((overtemp_oe & ~overtemp_out) | ext_low);
	mci_note_s   notes[$];
	mci_note_s   note;
	int          error_cnt = 0;
	int          checks = 0;
	int          cyc_cnt = 0;
	int          low_cnt = 0;
	int          init_cnt = 0;
	int          seed;
	logic [7:0]  v;

	mci_top #(.RST_PULSE_CYC(PULSE)) uut (
		.clock(clock), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp), .evt(evt),
		.scan_enable(scan_enable), .soft_init(soft_init), .intrusion_pin(intrusion_pin),
		.overtemp_in(overtemp_in), .overtemp_out(overtemp_out), .overtemp_oe(overtemp_oe),
		.alert_b(alert_b), .reset_out_b(reset_out_b)
	);

	always #4 clock = ~clock;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Watcher: every ack retires the oldest note
	always @(posedge clock) begin
		cyc_cnt <= cyc_cnt + 1;
		if (reset_out_b === 1'b0) low_cnt <= low_cnt + 1;
		if (soft_init === 1'b1) init_cnt <= init_cnt + 1;
		if (wb_rsp.ack === 1'b1) begin
			if (notes.size() == 0) chk("stray ack", 32'h0000_0000, 32'h0000_0001);
			else begin
				note = notes.pop_front();
				if (note.rd) chk($sformatf("read %h", note.adr), {24'h00_0000, note.exp}, wb_rsp.dat);
			end
		end
		if (cyc_cnt == LIMIT) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// Request stands until ack is seen high at a rising edge; only the bench timeout ends a wait
	task automatic bus(input logic we, input logic [9:0] adr, input logic [7:0] d, input logic [7:0] exp);
		notes.push_back('{rd: ~we, adr: adr, exp: exp});
		@(posedge clock);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: {24'h00_0000, d}};
		do begin
			@(posedge clock);
		end while (wb_rsp.ack !== 1'b1);
		wb_req <= '0;
	endtask

	task automatic pulse_evt(input mci_evt_s e);
		@(posedge clock);
		evt <= e;
		@(posedge clock);
		evt <= '0;
	endtask

	task automatic settle;
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask

	initial begin
		seed = 46;
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		@(negedge clock);
		chk_bit("alert_b", 1'b1, alert_b);
		chk_bit("reset_out_b", 1'b1, reset_out_b);
		chk_bit("scan_enable", 1'b0, scan_enable);
		bus(1'b0, A_CFG, 8'h00, 8'h00);
		bus(1'b0, A_ST1, 8'h00, 8'h00);
		bus(1'b0, A_ST2, 8'h00, 8'h00);
		bus(1'b1, A_BAD, 8'hFF, 8'h00);
		bus(1'b0, A_BAD, 8'h00, 8'h00);
		$display("test defaults done");
		// No limit registers live in this block, so start may be set at once
		bus(1'b1, A_CFG, 8'h03, 8'h00);
		bus(1'b0, A_CFG, 8'h00, 8'h03);
		chk_bit("scan_enable", 1'b1, scan_enable);
		v = 8'($random(seed));
		v = v | 8'h01;
		pulse_evt('{limit_one: v, default: '0});
		settle();
		chk_bit("alert_b", 1'b0, alert_b);
		bus(1'b0, A_ST1, 8'h00, v);
		bus(1'b0, A_ST1, 8'h00, 8'h00);
		settle();
		chk_bit("alert_b", 1'b1, alert_b);
		bus(1'b1, A_MK1, v, 8'h00);
		bus(1'b0, A_MK1, 8'h00, v);
		pulse_evt('{limit_one: v, default: '0});
		settle();
		chk_bit("alert_b", 1'b1, alert_b);
		bus(1'b0, A_ST1, 8'h00, v);
		bus(1'b1, A_MK1, 8'h00, 8'h00);
		$display("test flags and mask done");
		pulse_evt('{limit_two: 2'b11, default: '0});
		settle();
		chk_bit("alert_b", 1'b0, alert_b);
		bus(1'b1, A_CFG, 8'h02, 8'h00);
		settle();
		chk_bit("alert_b", 1'b0, alert_b);
		chk_bit("scan_enable", 1'b0, scan_enable);
		bus(1'b1, A_CFG, 8'h0B, 8'h00);
		settle();
		chk_bit("alert_b", 1'b1, alert_b);
		chk_bit("scan_enable", 1'b0, scan_enable);
		pulse_evt('{limit_one: 8'hFF, default: '0});
		bus(1'b0, A_ST2, 8'h00, 8'h03);
		bus(1'b0, A_ST1, 8'h00, 8'h00);
		bus(1'b1, A_CFG, 8'h03, 8'h00);
		$display("test alert clear done");
		pulse_evt('{temp_irq: 2'b11, diode_fault: 2'b11, default: '0});
		settle();
		chk_bit("overtemp_oe", 1'b0, overtemp_oe);
		bus(1'b0, A_ST1, 8'h00, 8'h30);
		bus(1'b0, A_ST2, 8'h00, 8'hC0);
		@(posedge clock);
		intrusion_pin <= 1'b1;
		settle();
		bus(1'b0, A_ST2, 8'h00, 8'h10);
		@(posedge clock);
		evt <= '{limit_one: 8'h03, default: '0};
		@(posedge clock);
		evt <= '{limit_one: 8'h01, default: '0};
		bus(1'b0, A_ST1, 8'h00, 8'h03);
		bus(1'b0, A_ST1, 8'h00, 8'h01);
		evt <= '0;
		bus(1'b0, A_ST1, 8'h00, 8'h01);
		bus(1'b0, A_ST1, 8'h00, 8'h00);
		$display("test event sources done");
		bus(1'b1, A_CFG, 8'h07, 8'h00);
		pulse_evt('{temp_irq: 2'b01, default: '0});
		settle();
		chk_bit("overtemp_oe", 1'b1, overtemp_oe);
		chk_bit("overtemp_out", 1'b0, overtemp_out);
		bus(1'b1, A_CFG, 8'h47, 8'h00);
		settle();
		chk_bit("overtemp_oe", 1'b0, overtemp_oe);
		bus(1'b0, A_CFG, 8'h00, 8'h07);
		bus(1'b0, A_ST1, 8'h00, 8'h10);
		repeat (6) @(posedge clock);
		ext_low <= 1'b1;
		repeat (8) @(posedge clock);
		ext_low <= 1'b0;
		settle();
		bus(1'b0, A_ST2, 8'h00, 8'h20);
		$display("test over-temp done");
		bus(1'b1, A_CFG, 8'h13, 8'h00);
		bus(1'b0, A_CFG, 8'h00, 8'h13);
		repeat (PULSE + 5) @(posedge clock);
		@(negedge clock);
		chk("reset pulse cycles", PULSE, low_cnt);
		bus(1'b0, A_CFG, 8'h00, 8'h03);
		$display("test reset pulse done");
		// Write of ones clears a flag as well as a read does
		pulse_evt('{limit_two: 2'b01, default: '0});
		bus(1'b1, A_ST2, 8'h01, 8'h00);
		bus(1'b0, A_ST2, 8'h00, 8'h00);
		bus(1'b1, A_MK1, 8'hA5, 8'h00);
		bus(1'b1, A_MK2, 8'h5A, 8'h00);
		bus(1'b0, A_MK2, 8'h00, 8'h5A);
		pulse_evt('{limit_one: 8'h80, default: '0});
		bus(1'b1, A_CFG, 8'h80, 8'h00);
		settle();
		chk("soft_init pulses", 32'h0000_0001, init_cnt);
		bus(1'b0, A_CFG, 8'h00, 8'h00);
		bus(1'b0, A_MK1, 8'h00, 8'h00);
		bus(1'b0, A_MK2, 8'h00, 8'h00);
		bus(1'b0, A_ST1, 8'h00, 8'h00);
		chk_bit("alert_b", 1'b1, alert_b);
		$display("test init done");
		repeat (3) @(posedge clock);
		tally_and_finish();
	end
endmodule
